// ---- hdl/lpc_link_power.sv ----
/*
 * Link power status watch and link-on wake control for the PHY side
 * of the parallel PHY-to-link interface.
 * Assumes clk is the interface clock base and that packet logic
 * elsewhere supplies transmit control and data and event pulses.
 */
`timescale 1ns/1ns
`default_nettype none

module lpc_link_power
  import lpc_pkg::*;
#(
  parameter int unsigned PORTS  = LPC_PORTS,
  parameter int unsigned DATA_W = LPC_DATA_W
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  // Link interface pins
  input  wire logic              link_power_status,
  input  wire logic              link_request_in,
  input  wire logic              iso_select,
  input  wire logic              contender_wake_pin_i,
  output var  logic              contender_wake_pin_o,
  output var  logic              contender_wake_pin_oe,
  output var  logic              interface_clock,
  output var  logic [LPC_CTRL_W-1:0] iface_ctrl_o,
  output var  logic              iface_ctrl_oe,
  output var  logic [DATA_W-1:0] iface_data_o,
  output var  logic              iface_data_oe,
  // Cable side
  input  wire logic [PORTS-1:0]  port_bias_detect,
  input  wire logic              cable_power_sense,
  output var  logic              cable_inactive_flag,
  output var  logic              cable_power_present,
  // Core control and events
  input  wire logic              link_control_bit,
  input  wire logic              port_event_bit,
  input  wire logic              config_timeout_bit,
  input  wire logic              cable_power_change_bit,
  input  wire logic              state_timeout_bit,
  input  wire logic              resume_port_enable_bit,
  input  wire logic              linkon_packet_rx,
  input  wire logic              bus_reset_evt,
  // Core transmit path
  input  wire logic              tx_drive,
  input  wire logic [LPC_CTRL_W-1:0] tx_ctrl,
  input  wire logic [DATA_W-1:0] tx_data,
  // Core status
  output logic                   link_request_seen,
  output logic                   llc_active,
  output logic                   differentiation_en,
  output var  logic              interface_clock_run,
  output var  logic              contender_default,
  output lpc_state_t             link_state
);

  localparam int unsigned NSYNC = PORTS + 5;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign pin_raw = {port_bias_detect, cable_power_sense,
                    contender_wake_pin_i, iso_select,
                    link_request_in, link_power_status};

  // First stage feeds only the second stage
  // No reset: the strap must be settled in the chain when reset lets go
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (ce) begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic             lps_s;
  logic             link_request_in_s;
  logic             iso_s;
  logic             strap_s;
  logic             cps_s;
  logic [PORTS-1:0] bias_s;

  assign lps_s   = sync2_q[0];
  assign link_request_in_s  = sync2_q[1];
  assign iso_s   = sync2_q[2];
  assign strap_s = sync2_q[3];
  assign cps_s   = sync2_q[4];
  assign bias_s  = sync2_q[NSYNC-1:5];

  // ************************************************************
  // Status monitor
  // ************************************************************
  lpc_mon_if mif ();

  assign mif.lps_sync = lps_s;
  assign mif.ce       = ce;

  lpc_lps_mon u_mon (
    .clk    (clk),
    .resetn (resetn),
    .mif    (mif)
  );

  assign link_state = mif.state;
  assign llc_active = (mif.state == LPC_ACTIVE) && link_control_bit;
  assign link_request_seen = (mif.state == LPC_ACTIVE) && link_request_in_s;
  assign differentiation_en = !iso_s;

  // ************************************************************
  // Link-on wake control
  // ************************************************************
  logic irq_wake;
  logic pkt_q;
  logic lkon_q;
  logic [LPC_WAVE_W-1:0] wave_q;

  assign irq_wake = port_event_bit
                  || (resume_port_enable_bit && (config_timeout_bit
                      || cable_power_change_bit || state_timeout_bit));

  // Packet cause kept apart so a bus reset can drop only that cause
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pkt_q <= 1'b0;
    end else if (ce) begin
      if (linkon_packet_rx && !llc_active) begin
        pkt_q <= 1'b1;
      end else if (bus_reset_evt || llc_active) begin
        pkt_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lkon_q <= 1'b0;
    end else if (ce) begin
      if (llc_active) begin
        lkon_q <= 1'b0;
      end else if (irq_wake) begin
        lkon_q <= 1'b1;
      end else if (linkon_packet_rx) begin
        lkon_q <= 1'b1;
      end else if (bus_reset_evt) begin
        lkon_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wave_q               <= '0;
      contender_wake_pin_o <= 1'b0;
    end else if (ce) begin
      if (lkon_q) begin
        wave_q <= wave_q + LPC_WAVE_W'(1);
      end else begin
        wave_q <= '0;
      end
      contender_wake_pin_o <= lkon_q && wave_q[LPC_WAVE_W-1];
    end
  end

  // Pin floats during reset so the strap can be read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      contender_wake_pin_oe <= 1'b0;
      contender_default     <= 1'b0;
    end else if (ce) begin
      contender_wake_pin_oe <= 1'b1;
      if (!contender_wake_pin_oe) begin
        contender_default <= strap_s;
      end
    end
  end

  // ************************************************************
  // Interface clock and link outputs
  // ************************************************************
  // The clock here is a divided image; a real part feeds a PLL
  always_ff @(posedge clk) begin
    if (!resetn) begin
      interface_clock     <= 1'b0;
      interface_clock_run <= 1'b0;
    end else if (ce) begin
      interface_clock_run <= (mif.state != LPC_DISABLED);
      interface_clock     <= (mif.state != LPC_DISABLED)
                             && !interface_clock;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      iface_ctrl_o  <= '0;
      iface_data_o  <= '0;
      iface_ctrl_oe <= 1'b1;
      iface_data_oe <= 1'b1;
    end else if (ce) begin
      if (mif.state == LPC_ACTIVE && tx_drive) begin
        iface_ctrl_o <= tx_ctrl;
        iface_data_o <= tx_data;
      end else begin
        iface_ctrl_o <= '0;
        iface_data_o <= '0;
      end
      iface_ctrl_oe <= (mif.state != LPC_ACTIVE) || tx_drive;
      iface_data_oe <= (mif.state != LPC_ACTIVE) || tx_drive;
    end
  end

  // ************************************************************
  // Cable status
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cable_inactive_flag <= 1'b1;
      cable_power_present <= 1'b0;
    end else if (ce) begin
      cable_inactive_flag <= ~|bias_s;
      cable_power_present <= cps_s;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_wake_hold: assert property (
    ce && lkon_q && !llc_active && !bus_reset_evt |=> lkon_q)
    else $error("wake output dropped before controller active");
  a_wake_stop: assert property (
    ce && llc_active |=> !lkon_q ##1 !contender_wake_pin_o)
    else $error("wake output kept after controller active");
  a_reset_drop: assert property (
    ce && bus_reset_evt && !irq_wake && !linkon_packet_rx
      |=> !lkon_q)
    else $error("bus reset did not stop packet wake");
  a_irq_wake: assert property (
    ce && irq_wake && !llc_active |=> lkon_q)
    else $error("pending interrupt did not start wake");
  a_pkt_wake: assert property (
    ce && linkon_packet_rx && !llc_active |=> lkon_q && pkt_q)
    else $error("link-on packet did not start wake");
  a_cable_flag: assert property (
    ce |=> cable_inactive_flag == ~|$past(bias_s))
    else $error("cable inactive flag wrong");
  a_iso_diff: assert property (
    ce ##1 ce |=> differentiation_en == !$past(iso_select, 2))
    else $error("differentiation enable wrong");
  a_quiet_outputs: assert property (
    ce && mif.state != LPC_ACTIVE
      |=> iface_ctrl_o == '0 && iface_data_o == '0)
    else $error("link outputs not held low when inactive");
  a_req_ignored: assert property (
    mif.state != LPC_ACTIVE |-> !link_request_seen)
    else $error("request seen while interface inactive");
  a_clock_stop: assert property (
    ce && mif.state == LPC_DISABLED
      |=> !interface_clock && !interface_clock_run)
    else $error("interface clock runs while disabled");
  a_reset_disabled: assert property (
    $rose(resetn) |-> mif.state == LPC_DISABLED && !interface_clock
      && !contender_wake_pin_oe)
    else $error("hardware reset did not disable interface");
  a_llc_active: assert property (
    !link_control_bit || mif.state != LPC_ACTIVE |-> !llc_active)
    else $error("controller active without both conditions");
  a_wave_period: assert property (
    (ce && lkon_q)[*6] |-> contender_wake_pin_o
      != $past(contender_wake_pin_o, 4))
    else $error("wake square wave period wrong");

  c_wake_pkt: cover property (linkon_packet_rx && !llc_active ##1 lkon_q);
  c_wake_irq: cover property (irq_wake && !llc_active ##1 lkon_q);
  c_wake_done: cover property (lkon_q ##1 llc_active);
  c_bus_reset: cover property (lkon_q && bus_reset_evt ##1 !lkon_q);

endmodule // lpc_link_power

`default_nettype wire

// ---- hdl/lpc_lps_mon.sv ----
/*
 * Low-time watcher for the synchronised link power status level.
 * Assumes the level is already synchronised to clk.
 */
`timescale 1ns/1ns
`default_nettype none

module lpc_lps_mon
  import lpc_pkg::*;
#(
  parameter int unsigned INACT_CYC = LPC_LOW_INACT_CYC,
  parameter int unsigned DIS_CYC   = LPC_LOW_DIS_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Carrier
  lpc_mon_if.mon    mif
);

  localparam logic [LPC_CNT_W-1:0] INACT_LIM = LPC_CNT_W'(INACT_CYC);
  localparam logic [LPC_CNT_W-1:0] DIS_LIM   = LPC_CNT_W'(DIS_CYC);
  localparam logic [LPC_CNT_W-1:0] SAT_LIM   = LPC_CNT_W'(DIS_CYC + 1);

  logic [LPC_CNT_W-1:0] low_cnt_q;
  logic [LPC_CNT_W-1:0] low_cnt_d;
  lpc_state_t           state_q;
  lpc_state_t           state_d;

  // ************************************************************
  // Low-time counter
  // ************************************************************
  // Reset loads the all-ones count, above the saturated value, so the link starts disabled
  always_comb begin
    if (mif.lps_sync) begin
      low_cnt_d = '0;
    end else if (low_cnt_q >= SAT_LIM) begin
      low_cnt_d = SAT_LIM;
    end else begin
      low_cnt_d = low_cnt_q + LPC_CNT_W'(1);
    end
  end

  always_comb begin
    if (low_cnt_d > DIS_LIM) begin
      state_d = LPC_DISABLED;
    end else if (low_cnt_d > INACT_LIM) begin
      state_d = LPC_LOWRST;
    end else begin
      state_d = LPC_ACTIVE;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      low_cnt_q <= LPC_CNT_RST;
      state_q   <= LPC_DISABLED;
    end else if (mif.ce) begin
      low_cnt_q <= low_cnt_d;
      state_q   <= state_d;
    end
  end

  assign mif.state = state_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_low_restart: assert property (
    mif.ce && mif.lps_sync |=> low_cnt_q == '0 && state_q == LPC_ACTIVE)
    else $error("low counter did not restart on high sample");
  a_inact_entry: assert property (
    mif.ce && !mif.lps_sync && low_cnt_q == INACT_LIM
      |=> state_q == LPC_LOWRST)
    else $error("low-power reset not entered after low time");
  a_inact_early: assert property (
    mif.ce && low_cnt_q < INACT_LIM |=> state_q == LPC_ACTIVE)
    else $error("status went inactive too early");
  a_dis_entry: assert property (
    mif.ce && !mif.lps_sync && low_cnt_q == DIS_LIM
      |=> state_q == LPC_DISABLED)
    else $error("disabled state not entered after long low time");

  c_goes_lowrst: cover property (
    state_q == LPC_ACTIVE ##1 state_q == LPC_LOWRST);
  c_goes_disabled: cover property (
    state_q == LPC_LOWRST ##1 state_q == LPC_DISABLED);

endmodule // lpc_lps_mon

`default_nettype wire

// ---- hdl/lpc_mon_if.sv ----
/*
 * Carrier between the link power monitor and the block top.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface lpc_mon_if
  import lpc_pkg::*;
  ();
  logic       lps_sync;
  logic       ce;
  lpc_state_t state;

  modport mon  (input lps_sync, input ce, output state);
  modport core (output lps_sync, output ce, input state);
endinterface // lpc_mon_if

`default_nettype wire

// ---- hdl/lpc_pkg.sv ----
/*
 * Constants and types shared by the link power control block.
 * Assumes a single core clock that also times the link interface clock.
 */
package lpc_pkg;

  // ************************************************************
  // Timing counts, in enabled clk cycles
  // ************************************************************
  localparam int unsigned LPC_LOW_INACT_CYC = 128;
  localparam int unsigned LPC_LOW_DIS_CYC   = 1280;
  localparam int unsigned LPC_WAKE_PERIOD   = 8;
  localparam int unsigned LPC_CNT_W         = 11;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int unsigned LPC_DATA_W   = 8;
  localparam int unsigned LPC_CTRL_W   = 2;
  localparam int unsigned LPC_PORTS    = 2;
  localparam int unsigned LPC_WAVE_W   = 3;
  localparam logic [LPC_CNT_W-1:0] LPC_CNT_RST = 11'h0_7ff;

  // ************************************************************
  // Link interface states
  // ************************************************************
  typedef enum logic [1:0] {
    LPC_ACTIVE,
    LPC_LOWRST,
    LPC_DISABLED
  } lpc_state_t;

endpackage

// ---- sim/lpc_llc_model.sv ----
/*
 * Link controller stand-in: drives link power status and the request pin.
 * Assumes the bench sets powered, pulsed and req just after the clk edge.
 */
`timescale 1ns/1ns
`default_nettype none

module lpc_llc_model (
  // Clock
  input  wire logic clk,
  // Bench controls
  input  wire logic powered,
  input  wire logic pulsed,
  input  wire logic req,
  // Link pins
  output logic      link_power_status,
  output logic      link_request_in
);
  // ************************************************************
  // Status and request drive
  // ************************************************************
  logic [1:0] ph_q = 2'h0;

  // One clk high in four: high phase is 100 ns, low time far below limit
  always @(posedge clk) begin
    ph_q <= ph_q + 2'h1;
  end

  assign link_power_status = powered & (!pulsed | ph_q == 2'h0);
  // An unpowered link leaves the request line wandering every cycle
  assign link_request_in = powered ? req : ph_q[0];
endmodule // lpc_llc_model

`default_nettype wire

// ---- sim/tb.sv ----
/*
 * Bench for the link power block: status watch, wake output, cable flag.
 * Assumes the link controller model drives the status and request pins.
 */
`timescale 1ns/1ns
`default_nettype none

module tb
  import lpc_pkg::*;
  ();
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic       clk, resetn, ce, iso_select, strap, powered, pulsed, req;
  logic       link_power_status, link_request_in, contender_wake_pin_i;
  logic       contender_wake_pin_o, contender_wake_pin_oe, interface_clock;
  logic       iface_ctrl_oe, iface_data_oe, cable_power_sense;
  logic       cable_inactive_flag, cable_power_present, link_control_bit;
  logic       port_event_bit, config_timeout_bit, cable_power_change_bit;
  logic       state_timeout_bit, resume_port_enable_bit, linkon_packet_rx;
  logic       bus_reset_evt, tx_drive, link_request_seen, llc_active;
  logic       differentiation_en, interface_clock_run, contender_default;
  logic       last_o, v;
  logic [1:0] iface_ctrl_o, tx_ctrl, port_bias_detect;
  logic [7:0] iface_data_o, tx_data;
  lpc_state_t link_state, last_st;
  lpc_state_t sq_st[$];
  int         errors, checked, cyc, last_rise, rises, n, e;
  int         sq_cyc[$], wq[$];

  // Strap resistor loses to the driven wake output
  assign contender_wake_pin_i =
    contender_wake_pin_oe ? contender_wake_pin_o : strap;

  lpc_link_power i_dut (
    .clk, .resetn, .ce, .link_power_status, .link_request_in, .iso_select,
    .contender_wake_pin_i, .contender_wake_pin_o, .contender_wake_pin_oe,
    .interface_clock, .iface_ctrl_o, .iface_ctrl_oe, .iface_data_o,
    .iface_data_oe, .port_bias_detect, .cable_power_sense,
    .cable_inactive_flag, .cable_power_present, .link_control_bit,
    .port_event_bit, .config_timeout_bit, .cable_power_change_bit,
    .state_timeout_bit, .resume_port_enable_bit, .linkon_packet_rx,
    .bus_reset_evt, .tx_drive, .tx_ctrl, .tx_data, .link_request_seen,
    .llc_active, .differentiation_en, .interface_clock_run,
    .contender_default, .link_state);

  lpc_llc_model i_llc (.clk, .powered, .pulsed, .req, .link_power_status,
    .link_request_in);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // ************************************************************
  // Checking
  // ************************************************************
  task automatic give_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_st(input lpc_state_t got, input lpc_state_t exp);
    cmp({30'h0, got}, {30'h0, exp});
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask

  task automatic note(input lpc_state_t s, input int d);
    sq_st.push_back(s);
    sq_cyc.push_back(cyc + d);
  endtask

  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task automatic quiet(input int k);
    tick(2);
    repeat (k) begin
      tick(1);
      cmp(contender_wake_pin_o, 1'b0);
    end
  endtask

  // Each state change or wake start is matched to the oldest note
  always @(posedge clk) begin
    #1;
    if (resetn === 1'b1 && link_state !== last_st) begin
      if (sq_st.size() == 0) begin
        cmp_st(link_state, last_st);
      end else begin
        cmp_st(link_state, sq_st.pop_front());
        cmp(cyc, sq_cyc.pop_front());
      end
    end
    last_st = link_state;
    if (contender_wake_pin_o === 1'b1 && last_o !== 1'b1) begin
      rises++;
      if (cyc - last_rise != 8) begin
        e = (wq.size() > 0) ? wq.pop_front() : -99;
        cmp(cyc >= e && cyc <= e + 3, 1'b1);
      end
      last_rise = cyc;
    end
    last_o = contender_wake_pin_o;
  end

  initial begin
    #1_000_000;
    errors++;
    give_verdict();
  end

  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    void'($urandom(70));
    {resetn, ce, iso_select, powered, pulsed, req} = 6'h18;
    strap = 1'($urandom);
    {port_bias_detect, cable_power_sense, link_control_bit} = 4'h0;
    {port_event_bit, config_timeout_bit, cable_power_change_bit} = 3'h0;
    {state_timeout_bit, resume_port_enable_bit, linkon_packet_rx} = 3'h0;
    {bus_reset_evt, tx_drive, tx_ctrl, tx_data} = 12'h000;
    last_st = LPC_DISABLED;
    last_rise = -100;
    tick(16);
    cmp({contender_wake_pin_oe, interface_clock_run}, 2'h0);
    cmp_st(link_state, LPC_DISABLED);
    resetn = 1'b1;
    tick(4);
    cmp({contender_wake_pin_oe, contender_wake_pin_o, contender_default},
      {2'h2, strap});
    repeat (12) begin
      {port_bias_detect, cable_power_sense, iso_select} = 4'($urandom);
      tick(3);
      cmp({cable_inactive_flag, cable_power_present, differentiation_en},
        {port_bias_detect == 2'h0, cable_power_sense, !iso_select});
    end
    powered = 1'b1;
    note(LPC_ACTIVE, 3);
    tick(6);
    v = interface_clock;
    ce = 1'b0;
    tick(3);
    cmp(interface_clock, v);
    ce = 1'b1;
    tick(1);
    cmp({interface_clock_run, interface_clock}, {1'b1, ~v});
    for (int i = 0; i < 2; i++) begin
      link_control_bit = i[0];
      req = !i[0];
      tick(3);
      cmp({llc_active, link_request_seen, iface_ctrl_oe, iface_data_oe},
        {i[0], !i[0], 2'h0});
    end
    tx_drive = 1'b1;
    {tx_ctrl, tx_data} = 10'($urandom);
    tick(1);
    cmp({iface_ctrl_o, iface_data_o}, {tx_ctrl, tx_data});
    pulsed = 1'b1;
    tick(300);
    pulsed = 1'b0;
    powered = 1'b0;
    tick(120);
    powered = 1'b1;
    tick(1);
    powered = 1'b0;
    tick(120);
    powered = 1'b1;
    tick(5);
    link_control_bit = 1'b0;
    powered = 1'b0;
    note(LPC_LOWRST, 131);
    note(LPC_DISABLED, 1283);
    {tx_ctrl, tx_data} = 10'h3a5;
    req = 1'b1;
    tick(200);
    repeat (4) begin
      tick(1);
      cmp({link_request_seen, iface_ctrl_o, iface_data_o,
        interface_clock_run, iface_ctrl_oe, iface_data_oe},
        14'h0007);
    end
    tick(1100);
    repeat (3) begin
      tick(1);
      cmp({interface_clock_run, interface_clock}, 2'h0);
    end
    tx_drive = 1'b0;
    wq.push_back(cyc + 4);
    strobe(linkon_packet_rx);
    tick(30);
    strobe(bus_reset_evt);
    quiet(20);
    powered = 1'b1;
    note(LPC_ACTIVE, 3);
    tick(6);
    for (int i = 0; i < 4; i++) begin
      resume_port_enable_bit = 1'b0;
      {port_event_bit, config_timeout_bit, cable_power_change_bit,
        state_timeout_bit} = 4'h8 >> i;
      if (i > 0) begin
        quiet(12);
        resume_port_enable_bit = 1'b1;
      end
      wq.push_back(cyc + 4);
      tick(20);
      n = rises;
      strobe(bus_reset_evt);
      {port_event_bit, config_timeout_bit, cable_power_change_bit,
        state_timeout_bit} = 4'h0;
      tick(24);
      cmp(rises - n >= 2, 1'b1);
      link_control_bit = 1'b1;
      quiet(12);
      link_control_bit = 1'b0;
    end
    link_control_bit = 1'b1;
    port_event_bit = 1'b1;
    strobe(linkon_packet_rx);
    quiet(12);
    link_control_bit = 1'b0;
    wq.push_back(cyc + 4);
    tick(20);
    link_control_bit = 1'b1;
    quiet(12);
    port_event_bit = 1'b0;
    cmp(wq.size() + sq_st.size(), 0);
    give_verdict();
  end
endmodule // tb

`default_nettype wire
